/* File: hw/led_gain_cfg.svh */
/*
 Register offsets, field positions, reset values and timing counts for the
 LED drive gain control block.
 Assumes a 50 MHz system clock and a 32768 Hz slow clock.
*/
`ifndef LED_GAIN_CFG_SVH
`define LED_GAIN_CFG_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define ADDR_ENABLE      8'h00
`define ADDR_CUR_R       8'h05
`define ADDR_CUR_G       8'h06
`define ADDR_CUR_B       8'h07
`define ADDR_CONFIG      8'h08
`define ADDR_STATUS      8'h0C
`define ENABLE_RESET     8'h00
`define CONFIG_RESET     8'h00
`define CURRENT_RESET    8'hAF
`define READ_UNMAPPED    8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LOG_EN_BIT       7
`define FAST_RATE_BIT    6
`define RED_BATT_BIT     5
`define GAIN_SEL_HI      4
`define GAIN_SEL_LO      3
`define EXT_CLK_BIT      0
`define GAIN_SEL_OFF     2'h0
`define GAIN_SEL_BYPASS  2'h1
`define GAIN_SEL_BOOST   2'h2
`define GAIN_SEL_AUTO    2'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SYS_HZ           50000000
`define SLOW_HZ          32768
`define FAST_PWM_HZ      558
`define PWM_STEPS        256
`define FAST_DIV         (`SYS_HZ / (`FAST_PWM_HZ * `PWM_STEPS))
`define SLOW_HALF_DIV    (`SYS_HZ / (2 * `SLOW_HZ))
`define IDLE_MS          50
`define IDLE_TICKS       ((`IDLE_MS * 2 * `SLOW_HZ + 999) / 1000)
`define FILTER_US        50
`define FILTER_CYC       ((`FILTER_US * (`SYS_HZ / 1000000)))

`endif

/* File: hw/led_gain_pkg.sv */
/*
 Types shared by the LED drive gain control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package led_gain_pkg;

   // ----------------------------------------------------------------------
   // pump gain state, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      GAIN_OFF    = 3'b001,
      GAIN_BYPASS = 3'b010,
      GAIN_BOOST  = 3'b100
   } gain_state_e;

   typedef logic [7:0] byte_t;

endpackage

/* File: hw/led_drive_gain_control.sv */
/*
 Gain control, current settings and PWM for a three-output LED driver.
 Assumes a byte register port already decoded from the serial interface,
 saturation flags and a 32 kHz clock arriving as asynchronous pins, and
 brightness values from engine logic on sys_clk.
*/
`timescale 1ns/100ps
`include "led_gain_cfg.svh"

module led_drive_gain_control (
   input  wire logic               sys_clk,        // 50 MHz clock
   input  wire logic               rst,            // async reset, high
   input  wire logic               reg_wr,         // register write strobe
   input  wire logic               reg_rd,         // register read strobe
   input  wire logic [7:0]         reg_addr,       // register address
   input  wire logic [7:0]         reg_wdata,      // write data
   input  wire logic               slow_clk_pin,   // external 32 kHz clock
   input  wire logic [2:0]         sat_pin,        // headroom lost, b/g/r
   input  wire logic [7:0]         pwm_r,          // red brightness
   input  wire logic [7:0]         pwm_g,          // green brightness
   input  wire logic [7:0]         pwm_b,          // blue brightness
   output logic      [7:0]         reg_rdata,      // read data
   output logic      [2:0]         led_on,         // pwm gates, b/g/r
   output logic      [7:0]         cur_r,          // red current code
   output logic      [7:0]         cur_g,          // green current code
   output logic      [7:0]         cur_b,          // blue current code
   output logic                    pump_enable,    // pump running
   output logic                    pump_boost,     // 1.5x when high
   output logic                    red_source_on_battery // red from battery
);

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // exponential curve: 1.5 bits mantissa shifted by the top three bits
   function automatic logic [7:0] log_map(input logic [7:0] lvl);
      logic [12:0] wide;
      wide = 13'({1'b1, lvl[4:0]}) << lvl[7:5];
      log_map = (lvl == 8'h00) ? 8'h00 : wide[12:5];
   endfunction

   function automatic logic pwm_gate(input logic [7:0] lvl,
                                     input logic       log_sel,
                                     input logic [7:0] phase);
      logic [7:0] duty;
      duty = log_sel ? log_map(lvl) : lvl;
      pwm_gate = phase < duty;
   endfunction

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [7:0] enable_ff, nxt_enable;
   logic [7:0] config_ff, nxt_config;
   logic [7:0] cur_r_ff, nxt_cur_r;
   logic [7:0] cur_g_ff, nxt_cur_g;
   logic [7:0] cur_b_ff, nxt_cur_b;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [2:0] sat_filt_ff;
   led_gain_pkg::gain_state_e gain_ff;

   // writes and reads; read data held until the next read
   always_comb begin
      nxt_enable = enable_ff;
      nxt_config = config_ff;
      nxt_cur_r  = cur_r_ff;
      nxt_cur_g  = cur_g_ff;
      nxt_cur_b  = cur_b_ff;
      nxt_rdata  = rdata_ff;
      if (reg_wr) begin
         unique case (reg_addr)
            `ADDR_ENABLE: nxt_enable = reg_wdata;
            `ADDR_CONFIG: nxt_config = reg_wdata;
            `ADDR_CUR_R:  nxt_cur_r  = reg_wdata;
            `ADDR_CUR_G:  nxt_cur_g  = reg_wdata;
            `ADDR_CUR_B:  nxt_cur_b  = reg_wdata;
            default:      nxt_enable = enable_ff;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `ADDR_ENABLE: nxt_rdata = enable_ff;
            `ADDR_CONFIG: nxt_rdata = config_ff;
            `ADDR_CUR_R:  nxt_rdata = cur_r_ff;
            `ADDR_CUR_G:  nxt_rdata = cur_g_ff;
            `ADDR_CUR_B:  nxt_rdata = cur_b_ff;
            `ADDR_STATUS: nxt_rdata = {2'h0, sat_filt_ff, gain_ff};
            default:      nxt_rdata = `READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enable_ff <= `ENABLE_RESET;
         config_ff <= `CONFIG_RESET;
         cur_r_ff  <= `CURRENT_RESET;
         cur_g_ff  <= `CURRENT_RESET;
         cur_b_ff  <= `CURRENT_RESET;
         rdata_ff  <= `READ_UNMAPPED;
      end else begin
         enable_ff <= nxt_enable;
         config_ff <= nxt_config;
         cur_r_ff  <= nxt_cur_r;
         cur_g_ff  <= nxt_cur_g;
         cur_b_ff  <= nxt_cur_b;
         rdata_ff  <= nxt_rdata;
      end
   end

   logic       log_en;
   logic       pwm_fast_rate_select;
   logic       red_batt;
   logic [1:0] pump_gain_select;
   logic       ext_clk_sel;

   // field decode
   assign log_en               = enable_ff[`LOG_EN_BIT];
   assign pwm_fast_rate_select = config_ff[`FAST_RATE_BIT];
   assign red_batt             = config_ff[`RED_BATT_BIT];
   assign pump_gain_select     = config_ff[`GAIN_SEL_HI:`GAIN_SEL_LO];
   assign ext_clk_sel          = config_ff[`EXT_CLK_BIT];

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   // three stages; a change counts once stages two and three agree
   logic [3:0] sync1_ff, sync2_ff, sync3_ff, stable_ff, nxt_stable;
   logic       slow_edge;

   always_comb begin
      nxt_stable = stable_ff;
      for (int i = 0; i < 4; i++) begin
         if (sync2_ff[i] == sync3_ff[i]) nxt_stable[i] = sync3_ff[i];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_ff  <= 4'h0;
         sync2_ff  <= 4'h0;
         sync3_ff  <= 4'h0;
         stable_ff <= 4'h0;
      end else begin
         sync1_ff  <= {slow_clk_pin, sat_pin};
         sync2_ff  <= sync1_ff;
         sync3_ff  <= sync2_ff;
         stable_ff <= nxt_stable;
      end
   end

   assign slow_edge = nxt_stable[3] != stable_ff[3];

   // ----------------------------------------------------------------------
   // rate dividers
   // ----------------------------------------------------------------------
   // internal slow clock runs at twice 32 kHz so both pin edges match it
   logic [10:0] half_div_ff, nxt_half_div;
   logic [8:0]  fast_div_ff, nxt_fast_div;
   logic        half_tick, fast_tick, slow_tick;

   always_comb begin
      half_tick    = half_div_ff == 11'(`SLOW_HALF_DIV - 1);
      fast_tick    = fast_div_ff == 9'(`FAST_DIV - 1);
      nxt_half_div = half_tick ? 11'h000 : half_div_ff + 11'h001;
      nxt_fast_div = fast_tick ? 9'h000 : fast_div_ff + 9'h001;
      slow_tick    = ext_clk_sel ? slow_edge : half_tick;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         half_div_ff <= 11'h000;
         fast_div_ff <= 9'h000;
      end else begin
         half_div_ff <= nxt_half_div;
         fast_div_ff <= nxt_fast_div;
      end
   end

   // ----------------------------------------------------------------------
   // saturation filter
   // ----------------------------------------------------------------------
   // a new level must hold for the full window; glitches restart the count
   logic [11:0] filt_cnt_ff [3];
   logic [11:0] nxt_filt_cnt [3];
   logic [2:0]  nxt_sat_filt;

   always_comb begin
      nxt_sat_filt = sat_filt_ff;
      for (int i = 0; i < 3; i++) begin
         nxt_filt_cnt[i] = 12'h000;
         if (stable_ff[i] != sat_filt_ff[i]) begin
            if (filt_cnt_ff[i] == 12'(`FILTER_CYC - 1)) begin
               nxt_sat_filt[i] = stable_ff[i];
            end else begin
               nxt_filt_cnt[i] = filt_cnt_ff[i] + 12'h001;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sat_filt_ff <= 3'h0;
         for (int i = 0; i < 3; i++) filt_cnt_ff[i] <= 12'h000;
      end else begin
         sat_filt_ff <= nxt_sat_filt;
         for (int i = 0; i < 3; i++) filt_cnt_ff[i] <= nxt_filt_cnt[i];
      end
   end

   // ----------------------------------------------------------------------
   // inactivity timer
   // ----------------------------------------------------------------------
   // counts slow half periods; saturates so idle stays asserted
   logic [11:0] idle_cnt_ff, nxt_idle_cnt;
   logic        leds_active, idle;

   always_comb begin
      leds_active = (pwm_r != 8'h00 && cur_r_ff != 8'h00) ||
                    (pwm_g != 8'h00 && cur_g_ff != 8'h00) ||
                    (pwm_b != 8'h00 && cur_b_ff != 8'h00);
      idle        = idle_cnt_ff >= 12'(`IDLE_TICKS);
      nxt_idle_cnt = idle_cnt_ff;
      if (leds_active) begin
         nxt_idle_cnt = 12'h000;
      end else if (slow_tick && !idle) begin
         nxt_idle_cnt = idle_cnt_ff + 12'h001;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) idle_cnt_ff <= 12'h000;
      else     idle_cnt_ff <= nxt_idle_cnt;
   end

   // ----------------------------------------------------------------------
   // pump gain state
   // ----------------------------------------------------------------------
   logic [2:0]                sat_used;
   logic                      nxt_pump_enable, nxt_pump_boost;
   led_gain_pkg::gain_state_e nxt_gain;

   always_comb begin
      // red is ignored when it runs straight from the battery
      sat_used = {sat_filt_ff[2:1], sat_filt_ff[0] & ~red_batt};
      unique case (pump_gain_select)
         `GAIN_SEL_OFF:    nxt_gain = led_gain_pkg::GAIN_OFF;
         `GAIN_SEL_BYPASS: nxt_gain = led_gain_pkg::GAIN_BYPASS;
         `GAIN_SEL_BOOST:  nxt_gain = led_gain_pkg::GAIN_BOOST;
         `GAIN_SEL_AUTO: begin
            if (idle)              nxt_gain = led_gain_pkg::GAIN_BYPASS;
            else if (|sat_used)    nxt_gain = led_gain_pkg::GAIN_BOOST;
            else                   nxt_gain = led_gain_pkg::GAIN_BYPASS;
         end
      endcase
      nxt_pump_enable = nxt_gain != led_gain_pkg::GAIN_OFF;
      nxt_pump_boost  = nxt_gain == led_gain_pkg::GAIN_BOOST;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gain_ff     <= led_gain_pkg::GAIN_OFF;
         pump_enable <= 1'b0;
         pump_boost  <= 1'b0;
      end else begin
         gain_ff     <= nxt_gain;
         pump_enable <= nxt_pump_enable;
         pump_boost  <= nxt_pump_boost;
      end
   end

   // ----------------------------------------------------------------------
   // pwm and output drive
   // ----------------------------------------------------------------------
   // slow rate steps on every 32 kHz edge: 65536 steps/s gives 256 Hz
   logic [7:0] phase_ff, nxt_phase;
   logic       step;
   logic [2:0] nxt_led_on;

   always_comb begin
      step      = pwm_fast_rate_select ? fast_tick : slow_tick;
      nxt_phase = step ? phase_ff + 8'h01 : phase_ff;
      nxt_led_on[0] = pwm_gate(pwm_r, log_en, phase_ff);
      nxt_led_on[1] = pwm_gate(pwm_g, log_en, phase_ff);
      nxt_led_on[2] = pwm_gate(pwm_b, log_en, phase_ff);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_ff              <= 8'h00;
         led_on                <= 3'h0;
         cur_r                 <= `CURRENT_RESET;
         cur_g                 <= `CURRENT_RESET;
         cur_b                 <= `CURRENT_RESET;
         red_source_on_battery <= 1'b0;
      end else begin
         phase_ff              <= nxt_phase;
         led_on                <= nxt_led_on;
         cur_r                 <= nxt_cur_r;
         cur_g                 <= nxt_cur_g;
         cur_b                 <= nxt_cur_b;
         red_source_on_battery <= nxt_config[`RED_BATT_BIT];
      end
   end

   assign reg_rdata = rdata_ff;

endmodule

/* File: sim/led_drive_gain_control_props.sv */
/*
 Concurrent checks on the ports of the LED drive gain control block.
 Assumes the register map and counts of led_gain_cfg.svh; bound below.
*/
`timescale 1ns/100ps
`include "led_gain_cfg.svh"

module led_drive_gain_control_props (
   input wire logic       sys_clk,               // system clock
   input wire logic       rst,                   // async reset, high
   input wire logic       reg_wr,                // write strobe
   input wire logic       reg_rd,                // read strobe
   input wire logic [7:0] reg_addr,              // register address
   input wire logic [7:0] reg_wdata,             // write data
   input wire logic       slow_clk_pin,          // slow clock pin
   input wire logic [2:0] sat_pin,               // headroom flags
   input wire logic [7:0] pwm_r,                 // red level
   input wire logic [7:0] pwm_g,                 // green level
   input wire logic [7:0] pwm_b,                 // blue level
   input wire logic [7:0] reg_rdata,             // read data
   input wire logic [2:0] led_on,                // pwm gates
   input wire logic [7:0] cur_r,                 // red current
   input wire logic [7:0] cur_g,                 // green current
   input wire logic [7:0] cur_b,                 // blue current
   input wire logic       pump_enable,           // pump running
   input wire logic       pump_boost,            // 1.5x gain
   input wire logic       red_source_on_battery  // red on battery
);
   logic [7:0]  cfg_ff;
   logic [7:0]  nxt_cfg;
   logic [11:0] stab_ff;
   logic [11:0] nxt_stab;
   logic [2:0]  sat_ff;

   // ---------------------------------------------------------------
   // shadow of config and a saturating age of the flag pattern
   // ---------------------------------------------------------------
   always_comb begin
      nxt_cfg = cfg_ff;
      if (reg_wr && reg_addr == `ADDR_CONFIG) begin
         nxt_cfg = reg_wdata;
      end
      nxt_stab = (sat_pin != sat_ff) ? 12'h000 :
                 ((stab_ff == 12'hFFF) ? stab_ff : stab_ff + 12'h001);
   end

   // registered so the shadow changes on the same edge as the real one
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_ff  <= `CONFIG_RESET;
         stab_ff <= 12'h000;
         sat_ff  <= 3'h0;
      end else begin
         cfg_ff  <= nxt_cfg;
         stab_ff <= nxt_stab;
         sat_ff  <= sat_pin;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   rst_vals_a: assert property ($fell(rst) |-> cur_r == `CURRENT_RESET &&
      cur_g == `CURRENT_RESET && cur_b == `CURRENT_RESET && !pump_enable &&
      !red_source_on_battery) else $error("reset values wrong");
   cur_wr_a: assert property (reg_wr && reg_addr == `ADDR_CUR_G |=>
      cur_g == $past(reg_wdata)) else $error("green current not written");
   cur_rd_a: assert property (reg_rd && reg_addr == `ADDR_CUR_R |=>
      reg_rdata == $past(cur_r)) else $error("red current read wrong");
   gain_off_a: assert property (cfg_ff[4:3] == `GAIN_SEL_OFF |=> !pump_enable)
      else $error("pump runs while off");
   gain_byp_a: assert property (cfg_ff[4:3] == `GAIN_SEL_BYPASS |=>
      pump_enable && !pump_boost) else $error("bypass not taken");
   gain_boost_a: assert property (cfg_ff[4:3] == `GAIN_SEL_BOOST |=>
      pump_enable && pump_boost) else $error("forced boost not taken");
   gain_auto_a: assert property (cfg_ff[4:3] == `GAIN_SEL_AUTO |=> pump_enable)
      else $error("pump stopped in auto");
   red_bit_a: assert property (red_source_on_battery == cfg_ff[`RED_BATT_BIT])
      else $error("red source bit differs");
   sat_filter_a: assert property (cfg_ff[4:3] == `GAIN_SEL_AUTO &&
      $past(cfg_ff, 2) == cfg_ff && $rose(pump_boost) |-> stab_ff > 12'h960)
      else $error("boost on unfiltered flags");

   boost_c: cover property (cfg_ff[4:3] == `GAIN_SEL_AUTO && $rose(pump_boost));
   idle_c:  cover property (cfg_ff[4:3] == `GAIN_SEL_AUTO && $fell(pump_boost));
   read_c:  cover property (reg_rd && reg_addr == `ADDR_CUR_R);
endmodule

bind led_drive_gain_control led_drive_gain_control_props u_props (
   .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .slow_clk_pin(slow_clk_pin),
   .sat_pin(sat_pin), .pwm_r(pwm_r), .pwm_g(pwm_g), .pwm_b(pwm_b),
   .reg_rdata(reg_rdata), .led_on(led_on), .cur_r(cur_r), .cur_g(cur_g),
   .cur_b(cur_b), .pump_enable(pump_enable), .pump_boost(pump_boost),
   .red_source_on_battery(red_source_on_battery));

/* File: sim/led_load_model.sv */
/*
 Behavioural three-LED load: reports lost headroom per driver.
 Assumes the bench sets supply level, which LEDs have a high forward
 voltage, and short disturbance pulses.
*/
`timescale 1ns/100ps

module led_load_model (
   input wire logic [7:0] cur_r,       // red current code
   input wire logic [7:0] cur_g,       // green current code
   input wire logic [7:0] cur_b,       // blue current code
   input wire logic       supply_low,  // supply below led need
   input wire logic [2:0] hi_vf,       // leds needing boost
   input wire logic [2:0] glitch,      // short disturbance
   output logic     [2:0] sat_pin      // headroom lost, b/g/r
);
   // a driver with no current set cannot saturate
   assign sat_pin = glitch | ({3{supply_low}} & hi_vf &
                    {cur_b != 8'h00, cur_g != 8'h00, cur_r != 8'h00});
endmodule

/* File: sim/tb_led_drive_gain_control.sv */
/*
 Self-checking bench for the LED drive gain control block.
 Assumes the led load model and the bound checker; drives slow clock.
*/
`timescale 1ns/100ps
`include "led_gain_cfg.svh"

module tb_led_drive_gain_control;
   logic       sys_clk = 1'b0;
   logic       rst, reg_wr, reg_rd, slow_clk_pin = 1'b0, supply_low;
   logic [7:0] reg_addr, reg_wdata, pwm_r, pwm_g, pwm_b, reg_rdata, cur_r, cur_g, cur_b, x;
   logic [2:0] sat_pin, led_on, hi_vf, glitch;
   logic [1:0] sdiv = 2'h0;
   logic       pump_enable, pump_boost, red_source_on_battery, rd_pend = 1'b0;
   logic [23:0] curs;
   logic [7:0] exp_q [$];
   int         err_total = 0, n_tests = 0, n, c [3];

   always #10 sys_clk = ~sys_clk;
   // slow clock edge every 4 cycles keeps idle and pwm runs short
   always @(posedge sys_clk) begin
      #1;
      sdiv <= sdiv + 2'h1;
      if (sdiv == 2'h3) slow_clk_pin <= ~slow_clk_pin;
   end
   assign curs = {cur_b, cur_g, cur_r};

   led_drive_gain_control dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .slow_clk_pin(slow_clk_pin), .sat_pin(sat_pin), .pwm_r(pwm_r), .pwm_g(pwm_g),
      .pwm_b(pwm_b), .reg_rdata(reg_rdata), .led_on(led_on), .cur_r(cur_r),
      .cur_g(cur_g), .cur_b(cur_b), .pump_enable(pump_enable), .pump_boost(pump_boost),
      .red_source_on_battery(red_source_on_battery));
   led_load_model load (.cur_r(cur_r), .cur_g(cur_g), .cur_b(cur_b),
      .supply_low(supply_low), .hi_vf(hi_vf), .glitch(glitch), .sat_pin(sat_pin));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("tests=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   // expected read data queued by the driver, taken by the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_rd = 1'b1; reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask
   // bounded wait on the gain output; must marks a hang as a failure
   task automatic wait_for(input logic v, input int lim, input bit must);
      n = 0;
      while (pump_boost !== v && n < lim) begin
         tick(1);
         n++;
      end
      if (must && n >= lim) begin
         err_total++;
         results();
      end
   endtask
   task automatic duty();
      c = '{0, 0, 0};
      repeat (1024) begin
         tick(1);
         for (int i = 0; i < 3; i++) c[i] += (led_on[i] === 1'b1);
      end
   endtask
   // time one phase step: find the phase by sweeping the red level, then
   // let three steps pass so the last count starts on a real step
   task automatic step_time(input logic [7:0] cfg, input int wrap);
      wr(`ADDR_CONFIG, cfg);
      repeat (2) begin
         x = 8'h00;
         for (int b = 7; b >= 0; b--) begin
            pwm_r = x | 8'(1 << b);
            tick(1);
            if (led_on[0] === 1'b0) x = pwm_r;
         end
         // too near the wrap: let the phase roll over and look again
         if (x > 8'hF4) tick(wrap);
      end
      for (int k = 1; k <= 3; k++) begin
         pwm_r = 8'(x + k);
         n = 0;
         do begin
            tick(1);
            n++;
         end while (led_on[0] !== 1'b0 && n < 1000);
         if (n >= 1000) begin
            err_total++;
            results();
         end
      end
   endtask
   function automatic int logv(input logic [7:0] l);
      logic [12:0] t;
      t = 13'({1'b1, l[4:0]}) << l[7:5];
      return (l == 8'h00) ? 0 : int'(t[12:5]);
   endfunction

   // ---------------------------------------------------------------
   // read monitor: result lands one edge after the read is taken
   // ---------------------------------------------------------------
   always @(posedge sys_clk) rd_pend <= reg_rd;
   always @(negedge sys_clk) begin
      if (rd_pend) check(reg_rdata, exp_q.pop_front());
   end

   initial begin
      rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      pwm_r = 8'h00; pwm_g = 8'h00; pwm_b = 8'h00; supply_low = 1'b0;
      hi_vf = 3'h0; glitch = 3'h0;
      void'($urandom(32'h0C2A));
      tick(2);
      rst = 1'b0;
      check(curs, {3{`CURRENT_RESET}});
      check({pump_enable, pump_boost, red_source_on_battery}, 3'b000);
      rd(`ADDR_ENABLE, `ENABLE_RESET);
      rd(`ADDR_CONFIG, `CONFIG_RESET);
      rd(8'h33, `READ_UNMAPPED);
      for (int i = 0; i < 3; i++) begin
         rd(8'(`ADDR_CUR_R + i), `CURRENT_RESET);
         for (int k = 0; k < 3; k++) begin
            x = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom_range(254, 1));
            wr(8'(`ADDR_CUR_R + i), x);
            rd(8'(`ADDR_CUR_R + i), x);
            check(curs[8*i +: 8], x);
         end
      end
      wr(8'h20, 8'h5A);
      rd(8'h20, `READ_UNMAPPED);
      // forced gain codes, status shows one-hot gain
      for (int g = 0; g < 3; g++) begin
         wr(`ADDR_CONFIG, 8'(g << 3));
         check({pump_enable, pump_boost}, (g == 0) ? 2'b00 : {1'b1, g == 2});
         rd(`ADDR_STATUS, {5'h00, 3'(1 << g)});
      end
      // automatic gain on external slow clock, leds active
      pwm_r = 8'($urandom_range(255, 1)); pwm_g = 8'($urandom_range(255, 1)); pwm_b = 8'hFF;
      wr(`ADDR_CONFIG, 8'h19);
      check({pump_enable, pump_boost}, 2'b10);
      glitch = 3'b010;
      tick(1000);
      glitch = 3'b000;
      wait_for(1'b1, 3000, 0);
      check(n, 3000);
      hi_vf = 3'b010; supply_low = 1'b1;
      wait_for(1'b1, 3500, 1);
      check(n >= 2500, 1);
      rd(`ADDR_STATUS, 8'h14);
      supply_low = 1'b0;
      wait_for(1'b0, 3500, 1);
      // red on battery is left out of the decision
      wr(`ADDR_CONFIG, 8'h39);
      hi_vf = 3'b001; supply_low = 1'b1;
      wait_for(1'b1, 4000, 0);
      check(n, 4000);
      check(red_source_on_battery, 1);
      wr(`ADDR_CONFIG, 8'h19);
      wait_for(1'b1, 100, 1);
      // all leds dark: 3277 half-ticks of 4 cycles, then bypass
      pwm_r = 8'h00; pwm_g = 8'h00; pwm_b = 8'h00;
      wait_for(1'b0, 14000, 1);
      check(n >= 13000, 1);
      // slow-rate pwm, linear then logarithmic mapping; pump off first so
      // waking the leds cannot raise boost on stale red flags
      supply_low = 1'b0;
      wr(`ADDR_CONFIG, 8'h01);
      pwm_r = 8'($urandom); pwm_g = 8'($urandom); pwm_b = 8'hFF;
      wr(`ADDR_ENABLE, 8'h00);
      tick(300);
      duty();
      check(c[0], 4 * pwm_r);
      check(c[1], 4 * pwm_g);
      check(c[2], 4 * pwm_b);
      wr(`ADDR_ENABLE, 8'h80);
      tick(300);
      duty();
      check(c[0], 4 * logv(pwm_r));
      check(c[1], 4 * logv(pwm_g));
      check(c[2], 1008);
      rd(`ADDR_ENABLE, 8'h80);
      // one phase step lasts a fast divider or an internal half-tick
      wr(`ADDR_ENABLE, 8'h00);
      step_time(8'h40, 3600);
      check(n, `FAST_DIV);
      step_time(8'h00, 7700);
      check(n, `SLOW_HALF_DIV);
      tick(4);
      results();
   end
endmodule
